// ==== logic/qsg_group.sv ====
// One status group: condition, transition filters, latched events, mask
`timescale 1ns/100ps
module qsg_group
   import qsg_pkg::*;
#(
   parameter logic [15:0] USED = 16'h0000
)(
   // Clock and control
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   // Live conditions
   input  wire logic [15:0] cond_live,
   // Register access
   input  wire logic        wr_en,
   input  wire logic [2:0]  wr_sel,
   input  wire logic [15:0] wr_data,
   input  wire logic        rd_latched,
   input  wire logic        clr_all,
   // State
   output qsg_regs_t        regs,
   output logic [15:0]      hit,
   output logic             summary
);

   qsg_regs_t   regs_ff;
   qsg_regs_t   nxt_regs;
   logic [15:0] rise_hit;
   logic [15:0] fall_hit;

   always_comb begin
      nxt_regs = regs_ff;
      // Unused bits and bit 15 are forced low here, so nothing downstream
      // can ever latch them
      nxt_regs.level = cond_live & USED;
      rise_hit = nxt_regs.level & ~regs_ff.level & regs_ff.rise;
      fall_hit = ~nxt_regs.level & regs_ff.level & regs_ff.fall;
      hit = rise_hit | fall_hit;
      // A new event in the clearing cycle survives the clear
      if (rd_latched || clr_all) begin
         nxt_regs.latched = LATCHED_RST;
      end
      nxt_regs.latched = nxt_regs.latched | hit;
      if (wr_en) begin
         case (wr_sel)
            SEL_RISE:  nxt_regs.rise = wr_data;
            SEL_FALL:  nxt_regs.fall = wr_data;
            SEL_MASK:  nxt_regs.mask = wr_data;
            default:   nxt_regs = nxt_regs;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         regs_ff.level   <= LEVEL_RST;
         regs_ff.rise    <= RISE_RST;
         regs_ff.fall    <= FALL_RST;
         regs_ff.latched <= LATCHED_RST;
         regs_ff.mask    <= MASK_RST;
      end else if (ce) begin
         regs_ff <= nxt_regs;
      end
   end

   assign regs    = regs_ff;
   assign summary = |(regs_ff.latched & regs_ff.mask);

endmodule

// ==== logic/qsg_pkg.sv ====
// Shared constants and carrier types for the two chained status groups
package qsg_pkg;

   localparam int          REG_W        = 16;
   localparam int          SEL_W        = 3;

   // Register select codes carried by a status command
   localparam logic [2:0]  SEL_LEVEL    = 3'h0;
   localparam logic [2:0]  SEL_RISE     = 3'h1;
   localparam logic [2:0]  SEL_FALL     = 3'h2;
   localparam logic [2:0]  SEL_LATCHED  = 3'h3;
   localparam logic [2:0]  SEL_MASK     = 3'h4;

   // Group select codes
   localparam logic        GRP_QUALITY  = 1'h0;
   localparam logic        GRP_SELFTEST = 1'h1;

   // Field positions
   localparam int          POS_ALWAYS0  = 15;
   localparam int          POS_QSUM     = 8;
   localparam int          POS_SA_CAL   = 0;
   localparam int          POS_SMP_CAL  = 1;
   localparam int          POS_CNT_CAL  = 2;
   localparam int          POS_VM_CAL   = 3;
   localparam int          POS_TXP_AZ   = 4;
   localparam int          FAIL_W       = 5;

   // Bits that carry a live condition; all others stay zero
   localparam logic [15:0] QUAL_USED    = 16'h0100;
   localparam logic [15:0] SELF_USED    = 16'h001F;

   // Reset values
   localparam logic [15:0] LEVEL_RST    = 16'h0000;
   localparam logic [15:0] RISE_RST     = 16'h0000;
   localparam logic [15:0] FALL_RST     = 16'h0000;
   localparam logic [15:0] LATCHED_RST  = 16'h0000;
   localparam logic [15:0] MASK_RST     = 16'h0000;
   localparam logic [15:0] RESP_RST     = 16'h0000;

   // One status command: query or write of one register of one group
   typedef struct packed {
      logic             wr;
      logic             grp;
      logic [2:0]       sel;
      logic [15:0]      data;
   } qsg_cmd_t;

   // Stored contents of one status group
   typedef struct packed {
      logic [15:0]      level;
      logic [15:0]      rise;
      logic [15:0]      fall;
      logic [15:0]      latched;
      logic [15:0]      mask;
   } qsg_regs_t;

endpackage

// ==== logic/qsg_top.sv ====
// Data-quality group chained to the self-test group, with command port
`timescale 1ns/100ps
module qsg_top
   import qsg_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        CLK,
   input  wire logic        SRST,
   input  wire logic        CE,
   // Status commands
   input  wire logic        CMD_VALID,
   input  wire qsg_cmd_t    CMD,
   input  wire logic        CLS,
   // Monitored failures
   input  wire logic [4:0]  CAL_FAIL,
   // Query answers
   output logic             RESP_VALID,
   output logic [15:0]      RESP_DATA,
   // Summaries
   output logic             QUAL_SUMMARY,
   output logic             CAL_SUMMARY
);

   logic        take;
   logic        is_wr;
   logic        is_rd;
   logic        q_sel;
   logic        s_sel;
   logic [15:0] self_live;
   logic [15:0] qual_live;
   qsg_regs_t   q_regs;
   qsg_regs_t   s_regs;
   logic [15:0] q_hit;
   logic [15:0] s_hit;
   logic        q_sum;
   logic        s_sum;
   logic        resp_valid_ff;
   logic        nxt_resp_valid;
   logic [15:0] resp_data_ff;
   logic [15:0] nxt_resp_data;
   qsg_regs_t   pick;

   // Command decode
   always_comb begin
      take  = CMD_VALID & CE;
      is_wr = take & CMD.wr;
      is_rd = take & ~CMD.wr;
      q_sel = (CMD.grp == GRP_QUALITY);
      s_sel = (CMD.grp == GRP_SELFTEST);
   end

   // Live condition vectors
   always_comb begin
      self_live = 16'h0000;
      self_live[POS_SA_CAL]  = CAL_FAIL[0];
      self_live[POS_SMP_CAL] = CAL_FAIL[1];
      self_live[POS_CNT_CAL] = CAL_FAIL[2];
      self_live[POS_VM_CAL]  = CAL_FAIL[3];
      self_live[POS_TXP_AZ]  = CAL_FAIL[4];
      qual_live = 16'h0000;
      // Summary is already a registered level, so the chain adds one
      // cycle of latency but no combinational path through both groups
      qual_live[POS_QSUM] = s_sum;
   end

   qsg_group #(
      .USED       (SELF_USED)
   ) u_self (
      .clk        (CLK),
      .srst       (SRST),
      .ce         (CE),
      .cond_live  (self_live),
      .wr_en      (is_wr & s_sel),
      .wr_sel     (CMD.sel),
      .wr_data    (CMD.data),
      .rd_latched (is_rd & s_sel & (CMD.sel == SEL_LATCHED)),
      .clr_all    (CLS & CE),
      .regs       (s_regs),
      .hit        (s_hit),
      .summary    (s_sum)
   );

   qsg_group #(
      .USED       (QUAL_USED)
   ) u_qual (
      .clk        (CLK),
      .srst       (SRST),
      .ce         (CE),
      .cond_live  (qual_live),
      .wr_en      (is_wr & q_sel),
      .wr_sel     (CMD.sel),
      .wr_data    (CMD.data),
      .rd_latched (is_rd & q_sel & (CMD.sel == SEL_LATCHED)),
      .clr_all    (CLS & CE),
      .regs       (q_regs),
      .hit        (q_hit),
      .summary    (q_sum)
   );

   // Query answer path
   always_comb begin
      pick = q_sel ? q_regs : s_regs;
      nxt_resp_valid = is_rd;
      nxt_resp_data  = resp_data_ff;
      if (is_rd) begin
         case (CMD.sel)
            SEL_LEVEL:   nxt_resp_data = pick.level;
            SEL_RISE:    nxt_resp_data = pick.rise;
            SEL_FALL:    nxt_resp_data = pick.fall;
            SEL_LATCHED: nxt_resp_data = pick.latched;
            SEL_MASK:    nxt_resp_data = pick.mask;
            default:     nxt_resp_data = RESP_RST;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         resp_valid_ff <= 1'b0;
         resp_data_ff  <= RESP_RST;
      end else if (CE) begin
         resp_valid_ff <= nxt_resp_valid;
         resp_data_ff  <= nxt_resp_data;
      end
   end

   assign RESP_VALID   = resp_valid_ff;
   assign RESP_DATA    = resp_data_ff;
   assign QUAL_SUMMARY = q_sum;
   assign CAL_SUMMARY  = s_sum;

   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   sequence s_query(logic [2:0] sel);
      is_rd && CMD.sel == sel;
   endsequence

   sequence s_answer(logic [15:0] val);
      RESP_VALID && RESP_DATA == val;
   endsequence

   a_bit15_zero: assert property (
      !q_regs.level[POS_ALWAYS0] && !s_regs.level[POS_ALWAYS0])
      else $error("condition bit 15 set");

   a_unused_bits_zero: assert property (
      (q_regs.level & ~QUAL_USED) == 16'h0000 &&
      (s_regs.latched & ~SELF_USED) == 16'h0000)
      else $error("unused condition or event bit set");

   a_chain_summary: assert property (
      CE && !SRST |=> q_regs.level[POS_QSUM] == $past(s_sum))
      else $error("quality bit 8 does not follow self-test summary");

   a_fail_map: assert property (
      CE && !SRST |=> s_regs.level[4:0] == $past(CAL_FAIL))
      else $error("self-test condition bits misplaced");

   a_query_clears: assert property (
      s_query(SEL_LATCHED) and CMD.grp == GRP_SELFTEST
      |=> s_answer($past(s_regs.latched))
          and (s_regs.latched & ~$past(s_hit)) == 16'h0000)
      else $error("event query did not answer and clear");

   a_cls_clears: assert property (
      CE && CLS |=> (q_regs.latched & ~$past(q_hit)) == 16'h0000
                 && (s_regs.latched & ~$past(s_hit)) == 16'h0000)
      else $error("clear-status left events");

   a_mask_held_zero: assert property (
      s_regs.mask == 16'h0000
      && !(is_wr && s_sel && CMD.sel == SEL_MASK)
      |=> s_regs.mask == 16'h0000)
      else $error("cleared mask changed without a write");

   a_filter_write: assert property (
      is_wr && q_sel && CMD.sel == SEL_FALL
      |=> q_regs.fall == $past(CMD.data))
      else $error("fall filter write lost");

   a_mask_readback: assert property (
      is_wr && s_sel && CMD.sel == SEL_MASK ##1
      (s_query(SEL_MASK) and s_sel)
      |=> s_answer($past(CMD.data, 2)))
      else $error("mask query wrong");

   a_level_readonly: assert property (
      is_wr && CMD.sel == SEL_LEVEL
      |=> !RESP_VALID && q_regs.mask == $past(q_regs.mask)
          && s_regs.rise == $past(s_regs.rise))
      else $error("condition write had an effect");

   a_rise_latch: assert property (
      CE && s_regs.rise[POS_TXP_AZ] && !s_regs.level[POS_TXP_AZ]
      && CAL_FAIL[4] |=> s_regs.latched[POS_TXP_AZ]
      && (!s_regs.mask[POS_TXP_AZ] || CAL_SUMMARY))
      else $error("rising failure not latched");

   a_summary_or: assert property (
      QUAL_SUMMARY == (q_regs.latched[POS_QSUM] && q_regs.mask[POS_QSUM]))
      else $error("quality summary mismatch");

   a_qual_query_clears: assert property (
      s_query(SEL_LATCHED) and CMD.grp == GRP_QUALITY
      |=> s_answer($past(q_regs.latched))
          and (q_regs.latched & ~$past(q_hit)) == 16'h0000)
      else $error("quality event query did not answer and clear");

   a_query_answer: assert property (
      is_rd |=> RESP_VALID)
      else $error("query gave no answer");

   a_no_stray_answer: assert property (
      CE && !is_rd |=> !RESP_VALID)
      else $error("answer without a query");

   a_answer_held: assert property (
      !SRST && !RESP_VALID |-> $stable(RESP_DATA))
      else $error("answer data changed without an answer");

   a_self_level_answer: assert property (
      s_query(SEL_LEVEL) and CMD.grp == GRP_SELFTEST
      |=> s_answer($past(s_regs.level)))
      else $error("self-test condition query wrong");

   a_qual_level_answer: assert property (
      s_query(SEL_LEVEL) and CMD.grp == GRP_QUALITY
      |=> s_answer($past(q_regs.level)))
      else $error("quality condition query wrong");

   a_filter_readback: assert property (
      is_wr && s_sel && CMD.sel == SEL_RISE ##1
      (s_query(SEL_RISE) and s_sel)
      |=> s_answer($past(CMD.data, 2)))
      else $error("rise filter query wrong");

   a_qual_mask_held: assert property (
      q_regs.mask == 16'h0000
      && !(is_wr && q_sel && CMD.sel == SEL_MASK)
      |=> q_regs.mask == 16'h0000)
      else $error("cleared quality mask changed without a write");

   a_mask_write: assert property (
      is_wr && q_sel && CMD.sel == SEL_MASK
      |=> q_regs.mask == $past(CMD.data))
      else $error("quality mask write lost");

   a_self_mask_write: assert property (
      is_wr && s_sel && CMD.sel == SEL_MASK
      |=> s_regs.mask == $past(CMD.data))
      else $error("self-test mask write lost");

   a_self_fall_write: assert property (
      is_wr && s_sel && CMD.sel == SEL_FALL
      |=> s_regs.fall == $past(CMD.data))
      else $error("self-test fall filter write lost");

   a_qual_rise_write: assert property (
      is_wr && q_sel && CMD.sel == SEL_RISE
      |=> q_regs.rise == $past(CMD.data))
      else $error("quality rise filter write lost");

   a_fall_latch: assert property (
      CE && s_regs.fall[POS_SA_CAL] && s_regs.level[POS_SA_CAL]
      && !CAL_FAIL[0] |=> s_regs.latched[POS_SA_CAL])
      else $error("falling failure not latched");

   a_chain_event: assert property (
      CE && !SRST && s_sum && !q_regs.level[POS_QSUM]
      && q_regs.rise[POS_QSUM] |=> q_regs.latched[POS_QSUM])
      else $error("self-test summary edge not latched");

   a_cls_quiet: assert property (
      CE && CLS && s_hit == 16'h0000 |=> !CAL_SUMMARY)
      else $error("summary survived clear-status");

   a_unused_quiet: assert property (
      (s_regs.level & ~SELF_USED) == 16'h0000 &&
      (q_regs.latched & ~QUAL_USED) == 16'h0000)
      else $error("unused bit set in condition or events");

   a_ce_freeze: assert property (
      !CE && !SRST |=> $stable(q_regs) && $stable(s_regs)
                   && $stable(RESP_VALID))
      else $error("state moved while clock enable low");

   a_blank_select: assert property (
      is_rd && CMD.sel > SEL_MASK |=> s_answer(16'h0000))
      else $error("unknown select did not answer zero");

   a_latched_readonly: assert property (
      is_wr && s_sel && CMD.sel == SEL_LATCHED && !CLS
      |=> s_regs.latched == ($past(s_regs.latched) | $past(s_hit)))
      else $error("event register write had an effect");

endmodule

// ==== testbench/qsg_ctl_model.sv ====
// Remote controller model: issues status queries, writes and clear-status
`timescale 1ns/100ps
module qsg_ctl_model
   import qsg_pkg::*;
(
   // Clock
   input  wire logic clk,
   // Command lines
   output logic      cmd_valid,
   output qsg_cmd_t  cmd,
   output logic      cls
);
   initial begin
      cmd_valid = 1'b0;
      cmd       = '0;
      cls       = 1'b0;
   end
   // One command per edge, so callers may chain them back to back
   task automatic issue(input logic wr, input logic grp,
                        input logic [2:0] sel, input logic [15:0] d,
                        input logic c);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd       <= '{wr, grp, sel, d};
      cls       <= c;
   endtask
   task automatic clear_mask(input logic grp);
      issue(1'b1, grp, SEL_MASK, 16'h0000, 1'b0);
   endtask
   // Idle lines carry inverted junk so a stale word never looks valid
   task automatic idle();
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd       <= ~cmd;
      cls       <= 1'b0;
   endtask
endmodule

// ==== testbench/tb_quality_and_selftest_status_groups.sv ====
// Self-checking bench for the chained quality and self-test status groups
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
   n_fail++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_quality_and_selftest_status_groups
   import qsg_pkg::*;
;
   logic        CLK = 0, SRST = 1, CE = 1, CMD_VALID, CLS;
   logic        RESP_VALID, QUAL_SUMMARY, CAL_SUMMARY;
   qsg_cmd_t    CMD;
   logic [4:0]  CAL_FAIL = 0;
   logic [15:0] RESP_DATA, e;
   logic [15:0] m_lvl[2], m_rise[2], m_fall[2], m_lat[2], m_msk[2], nl[2];
   logic [15:0] q[$];
   logic        ce_q = 0, armed = 0, cs, clr, qv = 0;
   int          n_fail = 0, total_checks = 0;

   always #20 CLK = ~CLK;

   qsg_top dut(.CLK(CLK), .SRST(SRST), .CE(CE), .CMD_VALID(CMD_VALID),
      .CMD(CMD), .CLS(CLS), .CAL_FAIL(CAL_FAIL), .RESP_VALID(RESP_VALID),
      .RESP_DATA(RESP_DATA), .QUAL_SUMMARY(QUAL_SUMMARY),
      .CAL_SUMMARY(CAL_SUMMARY));
   qsg_ctl_model ctl(.clk(CLK), .cmd_valid(CMD_VALID), .cmd(CMD),
      .cls(CLS));

   function automatic logic [15:0] rd(int g, logic [2:0] s);
      case (s)
         SEL_LEVEL:   return m_lvl[g];
         SEL_RISE:    return m_rise[g];
         SEL_FALL:    return m_fall[g];
         SEL_LATCHED: return m_lat[g];
         SEL_MASK:    return m_msk[g];
         default:     return 16'h0000;
      endcase
   endfunction

   // Reference model; a stretched answer while CE was low is not recounted
   always @(posedge CLK) begin
      if (armed && !SRST) begin
         if (ce_q) begin
            `CHK("valid", qv, RESP_VALID)
         end
         if (qv && ce_q) begin
            e = q.pop_front();
            `CHK("answer", e, RESP_DATA)
         end
         `CHK("qual sum", |(m_lat[0] & m_msk[0]), QUAL_SUMMARY)
         `CHK("cal sum", |(m_lat[1] & m_msk[1]), CAL_SUMMARY)
      end
      ce_q = CE;
      if (SRST && CE) begin
         for (int g = 0; g < 2; g++) begin
            {m_lvl[g], m_rise[g], m_fall[g], m_lat[g], m_msk[g]} = '0;
         end
         q.delete();
         qv    = 1'b0;
         armed = 1'b1;
      end else if (CE) begin
         qv    = CMD_VALID && !CMD.wr;
         cs    = |(m_lat[1] & m_msk[1]);
         nl[0] = {7'h00, cs, 8'h00};
         nl[1] = {11'h000, CAL_FAIL};
         for (int g = 0; g < 2; g++) begin
            if (CMD_VALID && CMD.grp == 1'(g) && !CMD.wr)
               q.push_back(rd(g, CMD.sel));
            clr = CLS || (CMD_VALID && CMD.grp == 1'(g) && !CMD.wr
                  && CMD.sel == SEL_LATCHED);
            m_lat[g] = (clr ? 16'h0000 : m_lat[g])
                     | (~m_lvl[g] & nl[g] & m_rise[g])
                     | (m_lvl[g] & ~nl[g] & m_fall[g]);
            if (CMD_VALID && CMD.grp == 1'(g) && CMD.wr) begin
               if (CMD.sel == SEL_RISE) m_rise[g] = CMD.data;
               if (CMD.sel == SEL_FALL) m_fall[g] = CMD.data;
               if (CMD.sel == SEL_MASK) m_msk[g] = CMD.data;
            end
            m_lvl[g] = nl[g];
         end
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      void'($urandom(2));
      repeat (5) @(posedge CLK);
      SRST <= 1'b0;
      // Every select written then queried, refused codes included
      for (int g = 0; g < 2; g++) begin
         for (int s = 0; s < 8; s++) begin
            ctl.issue(1'b1, 1'(g), 3'(s), 16'($urandom), 1'b0);
            ctl.issue(1'b0, 1'(g), 3'(s), 16'h0000, 1'b0);
         end
      end
      $display("test readback done");
      repeat (600) begin
         CAL_FAIL <= 5'($urandom);
         CE       <= ($urandom % 8) != 0;
         ctl.issue($urandom % 3 == 0, 1'($urandom), 3'($urandom % 5),
                   16'($urandom), $urandom % 16 == 0);
      end
      $display("test random traffic done");
      CE <= 1'b1;
      ctl.clear_mask(1'b0);
      ctl.clear_mask(1'b1);
      repeat (200) begin
         CAL_FAIL <= 5'($urandom);
         ctl.issue(1'b0, 1'($urandom), 3'($urandom % 8), 16'h0000, 1'b0);
      end
      $display("test mask cleared done");
      SRST <= 1'b1;
      ctl.idle();
      ctl.idle();
      SRST <= 1'b0;
      for (int s = 0; s < 10; s++) begin
         ctl.issue(1'b0, 1'(s / 5), 3'(s % 5), 16'h0000, 1'b0);
      end
      ctl.idle();
      ctl.idle();
      ctl.idle();
      $display("test mid-run reset done");
      close_out();
   end

   initial begin
      repeat (3000) @(posedge CLK);
      n_fail++;
      $display("watchdog expired");
      close_out();
   end
endmodule
